// *** logic/adcs_regs.sv ***
// Register file and conversion sequencer of the eight-input 8-bit converter.
// Assumes an APB master on core_clk, an analog core that samples on ana.sample
// and compares its input against ana.dac, and a standby level on core_clk.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE_01: Four read-only 8-bit result registers.
// RULE_02: Inputs n and n+4 share result register n.
// RULE_03: Results readable at any time.
// RULE_04: Results cleared on reset and standby.
// RULE_05: Control/status cleared on reset and standby.
// RULE_06: Trigger register loads 0x7e, trigger disabled.
// RULE_07: End flag set per conversion or scan pass.
// RULE_08: Flag cleared by read-one then write-zero.
// RULE_09: Interrupt requested when enabled and conversion completes.
// RULE_10: Conversions run only while start bit set.
// RULE_11: Single mode converts once, clears start.
// RULE_12: Scan mode repeats until start cleared.
// RULE_13: Mode bit: zero single, one scan.
// RULE_14: Conversion within 242 or 122 states.
// RULE_15: Software changes settings only while stopped.
// RULE_16: Single mode: group bit plus two-bit input.
// RULE_17: Scan converts group inputs zero up to selection.
// RULE_18: Enabled trigger pin sets start bit.
// RULE_19: Disabled trigger pin is ignored.
// RULE_20: Trigger bits 6..1 read one, ignore writes.
// RULE_21: Trigger bit 0 reserved, no effect.
// RULE_22: Trigger acts on falling pin edge.
// RULE_23: Eight approximation steps, result 0x00 to 0xff.
// RULE_24: Result stored in the converted channel's register.
// RULE_25: Interrupt held while flag and enable both set.
module adcs_regs #(
  parameter int unsigned ADDR_W = 18
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              standby,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_trig_n,
  input  wire logic              ana_cmp,
  output adcs_pkg::adcs_ana_t    ana,
  output logic                   conv_end_irq
);

  // Byte addresses of the registers, four times each index.
  localparam logic [ADDR_W-1:0] A_RES_A = ADDR_W'({adcs_pkg::IDX_RES_A, 2'b00});
  localparam logic [ADDR_W-1:0] A_RES_B = ADDR_W'({adcs_pkg::IDX_RES_B, 2'b00});
  localparam logic [ADDR_W-1:0] A_RES_C = ADDR_W'({adcs_pkg::IDX_RES_C, 2'b00});
  localparam logic [ADDR_W-1:0] A_RES_D = ADDR_W'({adcs_pkg::IDX_RES_D, 2'b00});
  localparam logic [ADDR_W-1:0] A_CSR   = ADDR_W'({adcs_pkg::IDX_CSR, 2'b00});
  localparam logic [ADDR_W-1:0] A_TRG   = ADDR_W'({adcs_pkg::IDX_TRG, 2'b00});
  localparam logic [4:0]        SLOW_L  = 5'(adcs_pkg::SLOW_STEP - 1);
  localparam logic [4:0]        FAST_L  = 5'(adcs_pkg::FAST_STEP - 1);
  localparam logic [4:0]        SMP_L   = 5'(adcs_pkg::SAMPLE_CYCLES - 1);

  // Pin synchronisers; stage one feeds only stage two.
  logic                  trig_s1;        // First trigger stage.
  logic                  trig_s2;        // Second trigger stage.
  logic                  trig_s3;        // Previous synchronised level.
  logic                  cmp_s1;         // First comparator stage.
  logic                  cmp_s2;         // Synchronised comparator.

  // Register and sequencer state with next values.
  adcs_pkg::adcs_csr_t   csr;            // Control/status register.
  adcs_pkg::adcs_csr_t   next_csr;
  logic                  trg_en;         // External trigger enable.
  logic                  next_trg_en;
  logic                  trg_rsv;        // Reserved bit, stored only.
  logic                  next_trg_rsv;
  logic [7:0]            res [4];        // Result registers A to D.
  logic [7:0]            next_res [4];
  logic                  flag_seen;      // Flag was read as one.
  logic                  next_flag_seen;
  logic                  ack;            // Access phase has waited once.
  logic                  next_ack;
  logic [31:0]           rdata;          // Captured read data.
  logic [31:0]           next_rdata;
  adcs_pkg::adcs_state_t state;          // Sequencer state.
  adcs_pkg::adcs_state_t next_state;
  logic [4:0]            cnt;            // Cycles within sample or step.
  logic [4:0]            next_cnt;
  logic [2:0]            bidx;           // Bit under trial.
  logic [2:0]            next_bidx;
  logic [1:0]            cur;            // Channel within group in scan.
  logic [1:0]            next_cur;
  logic [7:0]            code;           // Approximation register.
  logic [7:0]            next_code;
  adcs_pkg::adcs_ana_t   ana_q;          // Registered analog drive.
  adcs_pkg::adcs_ana_t   next_ana;

  // Combinational helpers.
  logic                  acc;            // Access phase present.
  logic                  hit;            // Address is mapped.
  logic                  trig_fall;      // Falling edge on trigger pin.
  logic [7:0]            sel_data;       // Read mux result.
  logic [1:0]            chan_idx;       // Channel being converted.
  logic [7:0]            done_code;      // Code with the bit under trial resolved.

  // The APB handshake is combinational; one wait state gives registered data.
  assign acc     = psel & penable;
  assign pready  = acc & ack & ce;
  assign pslverr = pready & ~hit;
  assign prdata  = rdata;
  assign ana     = ana_q;

  // Request persists while both enable and flag stand, dropping with either.
  assign conv_end_irq = csr.conv_end_flag & csr.conv_irq_enable; // RULE_09 RULE_25

  // A falling edge compares the second stage with the third stage only.
  assign trig_fall = trig_s3 & ~trig_s2; // RULE_22

  // Synchronisers run on every enabled clock; idle pin level is high.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_s3 <= 1'b1;
      cmp_s1  <= 1'b0;
      cmp_s2  <= 1'b0;
    end else if (ce) begin
      trig_s1 <= ext_trig_n;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      cmp_s1  <= ana_cmp;
      cmp_s2  <= cmp_s1;
    end
  end

  // Address decode and read multiplexer; trigger bits 6..1 read as one.
  always_comb begin
    hit      = 1'b1;
    sel_data = 8'h00;
    case (paddr)
      A_RES_A: sel_data = res[0]; // RULE_03
      A_RES_B: sel_data = res[1];
      A_RES_C: sel_data = res[2];
      A_RES_D: sel_data = res[3];
      A_CSR:   sel_data = csr;
      A_TRG:   sel_data = {trg_en, 6'h3f, trg_rsv} | adcs_pkg::TRG_ONES; // RULE_20
      default: hit = 1'b0;
    endcase
  end

  // Channel for the current conversion: direct in single mode, counted in scan.
  always_comb begin
    chan_idx  = csr.scan_mode ? cur : {csr.chan_sel_hi, csr.chan_sel_lo}; // RULE_13 RULE_16
    done_code = cmp_s2 ? code : (code & ~(8'h01 << bidx));
  end

  // Next-state logic for the registers, the bus and the sequencer.
  always_comb begin
    next_csr       = csr;
    next_trg_en    = trg_en;
    next_trg_rsv   = trg_rsv;
    next_res       = res;
    next_flag_seen = flag_seen;
    next_ack       = acc & ~ack;
    next_rdata     = rdata;
    next_state     = state;
    next_cnt       = cnt;
    next_bidx      = bidx;
    next_cur       = cur;
    next_code      = code;
    next_ana       = ana_q;

    // First access cycle captures read data; a flag read as one is noted.
    if (acc && !ack && !pwrite) begin
      next_rdata = {24'h000000, sel_data};
      if (paddr == A_CSR && csr.conv_end_flag) begin
        next_flag_seen = 1'b1; // RULE_08
      end
    end

    // Writes take effect at the completing edge; result registers ignore them.
    if (pready && pwrite && pstrb[0]) begin
      if (paddr == A_CSR) begin
        next_csr.conv_irq_enable = pwdata[6];
        next_csr.conv_start      = pwdata[5];
        next_csr.scan_mode       = pwdata[4];
        next_csr.conv_speed_sel  = pwdata[3];
        next_csr.group_sel       = pwdata[2];
        next_csr.chan_sel_hi     = pwdata[1];
        next_csr.chan_sel_lo     = pwdata[0];
        // Writing one to the flag does nothing; zero clears only after a read.
        if (!pwdata[7] && flag_seen) begin
          next_csr.conv_end_flag = 1'b0; // RULE_08
          next_flag_seen         = 1'b0;
        end
      end else if (paddr == A_TRG) begin
        next_trg_en  = pwdata[adcs_pkg::TRG_EN_BIT];
        next_trg_rsv = pwdata[adcs_pkg::TRG_RSV_BIT]; // RULE_21
      end
    end

    // The pin can only set the start bit, and only while enabled.
    if (trg_en && trig_fall) begin
      next_csr.conv_start = 1'b1; // RULE_18
    end // RULE_19

    // Sequencer.
    case (state)
      adcs_pkg::ADCS_IDLE: begin
        next_cnt = 5'h00;
        next_cur = 2'b00;
        if (csr.conv_start) begin
          next_state = adcs_pkg::ADCS_SAMPLE; // RULE_10
        end
      end
      adcs_pkg::ADCS_SAMPLE: begin
        next_cnt = cnt + 5'h01;
        if (cnt == SMP_L) begin
          next_state = adcs_pkg::ADCS_STEP;
          next_cnt   = 5'h00;
          next_bidx  = 3'h7;
          next_code  = 8'h80;
        end
      end
      adcs_pkg::ADCS_STEP: begin
        next_cnt = cnt + 5'h01;
        // Each step keeps its trial bit only if the input lies at or above it.
        if (cnt == (csr.conv_speed_sel ? FAST_L : SLOW_L)) begin // RULE_14
          next_cnt  = 5'h00;
          next_code = done_code; // RULE_23
          if (bidx != 3'h0) begin
            next_bidx = bidx - 3'h1;
            next_code = done_code | (8'h01 << (bidx - 3'h1));
          end else begin
            next_res[chan_idx] = done_code; // RULE_02 RULE_24
            if (!csr.scan_mode) begin
              next_state                = adcs_pkg::ADCS_IDLE;
              next_csr.conv_start       = 1'b0; // RULE_11
              next_csr.conv_end_flag    = 1'b1; // RULE_07
            end else begin
              // Scan wraps to the group's first input after the last one.
              next_state = adcs_pkg::ADCS_SAMPLE; // RULE_12
              if (cur == {csr.chan_sel_hi, csr.chan_sel_lo}) begin // RULE_17
                next_cur               = 2'b00;
                next_csr.conv_end_flag = 1'b1; // RULE_07
              end else begin
                next_cur = cur + 2'b01;
              end
            end
          end
        end
      end
      default: begin
        next_state = adcs_pkg::ADCS_IDLE;
      end
    endcase

    // Clearing the start bit stops the sequencer at once, mid-conversion too.
    if (!csr.conv_start && state != adcs_pkg::ADCS_IDLE) begin
      next_state = adcs_pkg::ADCS_IDLE; // RULE_10 RULE_12
    end

    // Analog drive follows the next state so it leaves a flip-flop.
    next_ana.sample = (next_state == adcs_pkg::ADCS_SAMPLE);
    next_ana.chan   = {csr.group_sel,
                       csr.scan_mode ? next_cur : {csr.chan_sel_hi, csr.chan_sel_lo}};
    next_ana.dac    = next_code;
  end

  // Reset and standby entry both return every register except the synchronisers to its default.
  always_ff @(posedge core_clk) begin
    if (!rst_n || standby) begin
      csr       <= adcs_pkg::CSR_RESET; // RULE_05
      trg_en    <= adcs_pkg::TRG_RESET[adcs_pkg::TRG_EN_BIT]; // RULE_06
      trg_rsv   <= adcs_pkg::TRG_RESET[adcs_pkg::TRG_RSV_BIT];
      for (int i = 0; i < 4; i++) begin
        res[i] <= adcs_pkg::RES_RESET; // RULE_01 RULE_04
      end
      flag_seen <= 1'b0;
      ack       <= 1'b0;
      rdata     <= 32'h00000000;
      state     <= adcs_pkg::ADCS_IDLE;
      cnt       <= 5'h00;
      bidx      <= 3'h0;
      cur       <= 2'b00;
      code      <= 8'h00;
      ana_q     <= '0;
    end else if (ce) begin
      csr       <= next_csr;
      trg_en    <= next_trg_en;
      trg_rsv   <= next_trg_rsv;
      res       <= next_res;
      flag_seen <= next_flag_seen;
      ack       <= next_ack;
      rdata     <= next_rdata;
      state     <= next_state;
      cnt       <= next_cnt;
      bidx      <= next_bidx;
      cur       <= next_cur;
      code      <= next_code;
      ana_q     <= next_ana;
    end
  end

endmodule : adcs_regs

`default_nettype wire

// *** logic/adcs_pkg.sv ***
// Shared constants and types for the eight-input converter sequencer.
// Assumes a single core clock; one state of conversion time is one clock cycle.
`default_nettype none

package adcs_pkg;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [15:0] IDX_RES_A = 16'hffe0;
  localparam logic [15:0] IDX_RES_B = 16'hffe2;
  localparam logic [15:0] IDX_RES_C = 16'hffe4;
  localparam logic [15:0] IDX_RES_D = 16'hffe6;
  localparam logic [15:0] IDX_CSR   = 16'hffe8;
  localparam logic [15:0] IDX_TRG   = 16'hffea;

  // Reset values.
  localparam logic [7:0] RES_RESET = 8'h00;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] TRG_RESET = 8'h7e;

  // Trigger register layout: bit 7 enables the pin, bits 6..1 read as one.
  localparam int unsigned TRG_EN_BIT   = 7;
  localparam int unsigned TRG_RSV_BIT  = 0;
  localparam logic [7:0]  TRG_ONES     = 8'h7e;

  // Conversion timing in states (clock cycles) for the two speeds.
  localparam int unsigned SLOW_CONV_STATES = 242;
  localparam int unsigned FAST_CONV_STATES = 122;
  localparam int unsigned SAR_BITS         = 8;
  localparam int unsigned SAMPLE_CYCLES    = 2;
  // Cycles per approximation step; rounded down so the limit is never passed.
  localparam int unsigned SLOW_STEP = (SLOW_CONV_STATES - SAMPLE_CYCLES) / SAR_BITS;
  localparam int unsigned FAST_STEP = (FAST_CONV_STATES - SAMPLE_CYCLES) / SAR_BITS;

  // Control/status register, laid out from bit 7 down to bit 0.
  typedef struct packed {
    logic conv_end_flag;
    logic conv_irq_enable;
    logic conv_start;
    logic scan_mode;
    logic conv_speed_sel;
    logic group_sel;
    logic chan_sel_hi;
    logic chan_sel_lo;
  } adcs_csr_t;

  // Drive towards the analog core: sample/hold, input select, trial code.
  typedef struct packed {
    logic       sample;
    logic [2:0] chan;
    logic [7:0] dac;
  } adcs_ana_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    ADCS_IDLE   = 2'b00,
    ADCS_SAMPLE = 2'b01,
    ADCS_STEP   = 2'b10
  } adcs_state_t;

endpackage : adcs_pkg

`default_nettype wire

// *** test/adcs_regs_asserts.sv ***
// Checker for the converter register block, watching its ports only.
// Assumes ce is held high and an APB master that waits for pready.
`timescale 1ns/1ps
`default_nettype none
module adcs_regs_asserts #(
  parameter int unsigned ADDR_W = 18
) (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                ce,
  input wire logic                standby,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire adcs_pkg::adcs_ana_t ana,
  input wire logic                conv_end_irq
);
  // Most checks hold outside reset; the reset check overrides this.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic mapped; // High when the address hits one of the six registers.
  assign mapped = paddr[1:0] == 2'b00 && paddr[ADDR_W-1:2] inside {adcs_pkg::IDX_RES_A,
    adcs_pkg::IDX_RES_B, adcs_pkg::IDX_RES_C, adcs_pkg::IDX_RES_D, adcs_pkg::IDX_CSR,
    adcs_pkg::IDX_TRG};
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_one_wait: assert property ($rose(psel && penable) && ce |-> !pready ##1 pready)
    else $error("read answer not after one wait state");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("error on a mapped register");
  a_byte_wide: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_trg_ones: assert property (pready && !pwrite && paddr[ADDR_W-1:2] == adcs_pkg::IDX_TRG
    |-> prdata[6:1] == 6'h3f)
    else $error("trigger bits six to one not ones");
  a_sample_two: assert property (ana.sample ##1 ana.sample |=> !ana.sample)
    else $error("sample phase length wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !pready && !pslverr
    && !conv_end_irq && ana == '0)
    else $error("outputs not quiet after reset");
  a_standby_quiet: assert property (standby |=> !conv_end_irq && ana == '0)
    else $error("standby did not stop the converter");
  // Main scenarios: a conversion, an end request and a refused access.
  c_conv: cover property ($rose(ana.sample));
  c_irq: cover property ($rose(conv_end_irq));
  c_err: cover property (pslverr);
endmodule : adcs_regs_asserts
bind adcs_regs adcs_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.core_clk(core_clk),
  .rst_n(rst_n), .ce(ce), .standby(standby), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ana(ana), .conv_end_irq(conv_end_irq));
`default_nettype wire

// *** test/adcs_far.sv ***
// Far-side model: analog inputs held as ideal codes, and the trigger pin.
// Assumes the block synchronises both the comparator and the pin itself.
`timescale 1ns/1ps
`default_nettype none
module adcs_far (
  input  wire logic                core_clk,
  input  wire adcs_pkg::adcs_ana_t ana,
  output logic                     ana_cmp,
  output logic                     ext_trig_n
);
  logic [7:0] volt [8]; // Level of each input; the bench sets them.
  // Comparator is high when the selected input reaches the trial code.
  always_comb ana_cmp = volt[ana.chan] >= ana.dac;
  // The pin idles high, so only a deliberate fall can start anything.
  initial begin
    ext_trig_n = 1'b1;
    foreach (volt[i]) volt[i] = 8'h00;
  end
  // Falling edge held low four cycles, changed just after clock edges.
  task automatic fall();
    @(posedge core_clk) ext_trig_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    ext_trig_n <= 1'b1;
  endtask : fall
endmodule : adcs_far
`default_nettype wire

// *** test/adcs_regs_tb.sv ***
// Self-checking bench for the converter register block over APB.
// Assumes the far-side model and the bound checker; ce stays high.
`timescale 1ns/1ps
`default_nettype none
module adcs_regs_tb;
  logic                core_clk = 1'b0;
  logic                rst_n, ce, standby, psel, penable, pwrite;
  logic [17:0]         paddr;
  logic [31:0]         pwdata, prdata;
  logic [3:0]          pstrb;
  logic                pready, pslverr, ext_trig_n, ana_cmp, conv_end_irq;
  adcs_pkg::adcs_ana_t ana;
  int                  bad_count, checks, seed, n;
  logic [32:0]         expq [$]; // Expected {pslverr, prdata} of reads in order.
  logic [7:0]          v;
  logic [3:0]          ch;
  always #2.5 core_clk = ~core_clk;
  adcs_regs dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .standby(standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trig_n(ext_trig_n), .ana_cmp(ana_cmp), .ana(ana), .conv_end_irq(conv_end_irq));
  adcs_far far (.core_clk(core_clk), .ana(ana), .ana_cmp(ana_cmp), .ext_trig_n(ext_trig_n));
  // Counts and reports one mismatch.
  task automatic fail(input string s);
    bad_count++;
    $display("Error %0t: %s", $time, s);
  endtask : fail
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // One APB transfer; pready is sampled at each rising edge, and the request is
  // released only after the edge at which it was seen high.
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
    @(posedge core_clk) penable <= 1'b1;
    k = 0;
    do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin fail("no pready"); tally_and_finish(); end
  endtask : apb
  // A read whose expected answer is noted for the monitor first.
  task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic err);
    expq.push_back({err, 24'h0, e});
    apb(1'b0, idx, 8'h00);
  endtask : rd
  // Waits for the end request, counting falling edges, under a bound.
  task automatic wait_irq(input int lim);
    n = 0;
    while (conv_end_irq !== 1'b1 && n < lim) begin @(negedge core_clk); n++; end
    if (n >= lim) begin fail("no end request"); tally_and_finish(); end
  endtask : wait_irq
  // Compares the request level on the next falling edge.
  task automatic see_irq(input logic e);
    @(negedge core_clk);
    checks++;
    if (conv_end_irq !== e) fail("request level");
  endtask : see_irq
  // All six registers at their initial values.
  task automatic chk_reset();
    for (int i = 0; i < 4; i++) rd(adcs_pkg::IDX_RES_A + 16'(2 * i), 8'h00, 1'b0);
    rd(adcs_pkg::IDX_CSR, adcs_pkg::CSR_RESET, 1'b0);
    rd(adcs_pkg::IDX_TRG, adcs_pkg::TRG_RESET, 1'b0);
  endtask : chk_reset
  // Monitor: each read answer is compared with the oldest note.
  always @(posedge core_clk) if (psel && penable && pready && !pwrite) begin
    checks++;
    if (expq.size() == 0 || {pslverr, prdata} !== expq[0]) fail("read data");
    if (expq.size() != 0) void'(expq.pop_front());
  end
  // Main sequence.
  initial begin
    seed = 32'h7a5ef53d;
    {rst_n, standby, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    pstrb = 4'hf;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    chk_reset();
    rd(16'hffe9, 8'h00, 1'b1);
    apb(1'b1, adcs_pkg::IDX_RES_A, 8'h55);
    rd(adcs_pkg::IDX_RES_A, 8'h00, 1'b0);
    apb(1'b1, adcs_pkg::IDX_TRG, 8'h01);
    rd(adcs_pkg::IDX_TRG, 8'h7f, 1'b0);
    apb(1'b1, adcs_pkg::IDX_TRG, 8'h00);
    rd(adcs_pkg::IDX_TRG, 8'h7e, 1'b0);
    apb(1'b1, adcs_pkg::IDX_CSR, 8'h80);
    rd(adcs_pkg::IDX_CSR, 8'h00, 1'b0);
    // Single mode on every input, both speeds, random levels.
    for (ch = 0; ch < 8; ch++) begin
      v = 8'($random(seed));
      far.volt[ch] = v;
      apb(1'b1, adcs_pkg::IDX_CSR, {4'b0110, ch[0], ch[2:0]});
      wait_irq(400);
      checks++;
      if (n > (ch[0] ? 122 : 242) + 6) fail("conversion too slow");
      rd(adcs_pkg::IDX_CSR, {4'b1100, ch[0], ch[2:0]}, 1'b0);
      apb(1'b1, adcs_pkg::IDX_CSR, 8'h40);
      rd(adcs_pkg::IDX_CSR, 8'h40, 1'b0);
      rd(adcs_pkg::IDX_RES_A + {13'h0, ch[1:0], 1'b0}, v, 1'b0);
    end
    // Enable off: no request; then enable on with flag, then flag cleared.
    apb(1'b1, adcs_pkg::IDX_CSR, 8'h22);
    repeat (260) @(posedge core_clk);
    see_irq(1'b0);
    rd(adcs_pkg::IDX_CSR, 8'h82, 1'b0);
    apb(1'b1, adcs_pkg::IDX_CSR, 8'hc2);
    see_irq(1'b1);
    apb(1'b1, adcs_pkg::IDX_CSR, 8'h40);
    see_irq(1'b0);
    // Scan of inputs four to six, fast, read while still running.
    for (int i = 4; i < 7; i++) far.volt[i] = 8'($random(seed));
    apb(1'b1, adcs_pkg::IDX_CSR, 8'h7e);
    wait_irq(600);
    checks++;
    if (n > 3 * 122 + 8) fail("scan pass too slow");
    for (int i = 0; i < 3; i++) rd(adcs_pkg::IDX_RES_A + 16'(2 * i), far.volt[i + 4], 1'b0);
    rd(adcs_pkg::IDX_CSR, 8'hfe, 1'b0);
    apb(1'b1, adcs_pkg::IDX_CSR, 8'h00);
    rd(adcs_pkg::IDX_CSR, 8'h00, 1'b0);
    // Trigger pin ignored while disabled, then starts a conversion.
    apb(1'b1, adcs_pkg::IDX_CSR, 8'h41);
    far.fall();
    repeat (20) @(posedge core_clk);
    rd(adcs_pkg::IDX_CSR, 8'h41, 1'b0);
    apb(1'b1, adcs_pkg::IDX_TRG, 8'h80);
    rd(adcs_pkg::IDX_TRG, 8'hfe, 1'b0);
    // A fresh level makes the result prove that this conversion really ran.
    far.volt[1] = 8'($random(seed));
    far.fall();
    wait_irq(400);
    rd(adcs_pkg::IDX_CSR, 8'hc1, 1'b0);
    rd(adcs_pkg::IDX_RES_B, far.volt[1], 1'b0);
    // Standby in the middle of a scan returns everything to defaults.
    apb(1'b1, adcs_pkg::IDX_CSR, 8'h33);
    repeat (100) @(posedge core_clk);
    standby <= 1'b1;
    repeat (2) @(posedge core_clk);
    standby <= 1'b0;
    chk_reset();
    repeat (4) @(posedge core_clk);
    tally_and_finish();
  end
endmodule : adcs_regs_tb
`default_nettype wire
